// ---- nvrc_ctrl.v ----
// Purpose: nonvolatile memory read access control between cpu and arrays
// Assumes: arrays answer reads combinationally; cpu honours stall
// Notes: register file on AXI4-Lite; guards come from config pins
// Function
// - two memories, flash and eeprom, via pointer and register interface
// - code guard blocks register read triggers and self-write; only the pins lift it
// - write guard range blocks self-write and erase, not programmer
// - flash words are 14 bits, with id, config and vector space
// - flash read by fetch and pointer; register interface reads and writes
// - every read returns exactly one memory word
// - erased flash bits read one; programming only clears bits
// - rows of 32 words, 32 write latches, 8192 words total
// - write latches filled only through the data register pair
// - erased words may be programmed without prior row erase
// - self-programming allows row write and row erase, rejects bulk erase
// - eeprom holds 256 bytes, read by pointer and register interface
// - eeprom written per word; flash written per row
// - pointer load with nonvolatile address returns that location's data
// - pointer read takes one cycle, cpu suspended then resumes
// - pointer store instructions never modify nonvolatile memory
// - register interface reaches pointer space, ids; write trigger on id and config raises row program or erase
// - code guarded device refuses register interface read and write triggers
// - after trigger cpu stalls and data lands next cycle
// - data pair holds result until next read or software write
// - hardware clears read trigger when read completes
`timescale 1ns/1ps
`default_nettype none
`include "nvrc_defs.vh"
module nvrc_ctrl #(
    parameter PFM_AW = 13,
    parameter ROW_WORDS = `NVRC_ROW_WORDS
) (
    input wire aclk,
    input wire aresetn,
    // axi4-lite slave
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // cpu indirect pointer port
    input wire ptr_rd,
    input wire ptr_wr,
    input wire [15:0] indirect_pointer,
    output reg [13:0] ptr_data_q,
    output reg ptr_valid_q,
    output reg cpu_stall_q,
    // configuration straps, pins
    input wire code_guard_flash_n,
    input wire code_guard_eeprom_n,
    input wire [1:0] write_guard_range,
    // array read ports
    output reg [PFM_AW-1:0] pfm_addr_q,
    input wire [13:0] pfm_rdata,
    output reg [7:0] ee_addr_q,
    input wire [7:0] ee_rdata,
    output reg [14:0] cfg_addr_q,
    input wire [13:0] cfg_rdata,
    // array write request (taken by the programming sequencer)
    output reg prog_row_q,
    output reg erase_row_q,
    output reg ee_write_q,
    output reg [13:0] prog_data_q
);
    // ****************************************
    // configuration synchronisers
    // ****************************************
    reg [3:0] cfg_s1_q;
    reg [3:0] cfg_s2_q;
    always @(posedge aclk) begin
        if (!aresetn) begin
            cfg_s1_q <= 4'h0;
            cfg_s2_q <= 4'h0;
        end else begin
            cfg_s1_q <= {code_guard_flash_n, code_guard_eeprom_n, write_guard_range};
            cfg_s2_q <= cfg_s1_q;
        end
    end
    wire guard_flash = ~cfg_s2_q[3];
    wire guard_ee = ~cfg_s2_q[2];
    wire [1:0] wrange = cfg_s2_q[1:0];
    // guarded device refuses register interface read and write triggers
    wire reg_locked = guard_flash | guard_ee;

    // ****************************************
    // registers
    // ****************************************
    reg rd_q;
    reg space_select_bit_q;
    reg wren_q;
    reg free_q;
    reg [7:0] address_low_byte_q;
    reg [6:0] address_high_byte_q;
    reg [7:0] data_low_byte_q;
    reg [5:0] data_high_byte_q;
    reg blocked_q;
    reg bulk_rej_q;
    reg wprot_q;
    reg store_rej_q;
    reg pend_q;
    wire [14:0] nv_addr = {address_high_byte_q, address_low_byte_q};
    wire [4:0] fill_idx;
    wire [13:0] latch_rd;

    // write protection: 00 all, 01 lower half, 10 lower eighth, 11 none
    reg wp_hit;
    always @* begin
        case (wrange)
            2'b00: wp_hit = 1'b1;
            2'b01: wp_hit = (nv_addr[12:0] < 13'h1000);
            2'b10: wp_hit = (nv_addr[12:0] < 13'h0400);
            default: wp_hit = 1'b0;
        endcase
    end

    // ****************************************
    // axi write channel
    // ****************************************
    reg aw_held_q;
    reg w_held_q;
    reg [11:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    wire wr_go = aw_held_q & w_held_q & ~s_axi_bvalid;
    wire wr_ctrl = wr_go & (awaddr_q == `NVRC_OFF_CTRL) & wstrb_q[0];
    wire wr_dlo = wr_go & (awaddr_q == `NVRC_OFF_DATA_LO) & wstrb_q[0];
    wire wr_dhi = wr_go & (awaddr_q == `NVRC_OFF_DATA_HI) & wstrb_q[0];
    wire wr_map = (awaddr_q == `NVRC_OFF_CTRL) || (awaddr_q == `NVRC_OFF_ADDR_LO) ||
        (awaddr_q == `NVRC_OFF_ADDR_HI) || (awaddr_q == `NVRC_OFF_DATA_LO) ||
        (awaddr_q == `NVRC_OFF_DATA_HI) || (awaddr_q == `NVRC_OFF_STATUS);
    // high byte write completes the word and, with wren set in flash space, fills the next latch
    wire latch_load = wr_dhi & wren_q & ~space_select_bit_q;
    wire trig_rd = wr_ctrl & wdata_q[`NVRC_CTRL_RD];
    wire trig_bulk = wr_ctrl & wdata_q[`NVRC_CTRL_BULK];

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 12'h000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `NVRC_RESP_OKAY;
        end else begin
            s_axi_awready <= ~aw_held_q & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready <= ~w_held_q & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q <= {s_axi_awaddr[11:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_map ? `NVRC_RESP_OKAY : `NVRC_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // control, address and status registers
    // ****************************************
    wire reg_rd_done;
    always @(posedge aclk) begin
        if (!aresetn) begin
            rd_q <= 1'b0;
            space_select_bit_q <= 1'b0;
            wren_q <= 1'b0;
            free_q <= 1'b0;
            address_low_byte_q <= 8'h00;
            address_high_byte_q <= 7'h00;
            blocked_q <= 1'b0;
            bulk_rej_q <= 1'b0;
            wprot_q <= 1'b0;
            store_rej_q <= 1'b0;
            prog_row_q <= 1'b0;
            erase_row_q <= 1'b0;
            ee_write_q <= 1'b0;
            prog_data_q <= 14'h0000;
        end else begin
            prog_row_q <= 1'b0;
            erase_row_q <= 1'b0;
            ee_write_q <= 1'b0;
            if (wr_ctrl) begin
                space_select_bit_q <= wdata_q[`NVRC_CTRL_SPACE];
                wren_q <= wdata_q[`NVRC_CTRL_WREN];
                free_q <= wdata_q[`NVRC_CTRL_FREE];
                // sticky flags: writing one clears
                if (wdata_q[8 + `NVRC_ST_BLOCKED]) blocked_q <= 1'b0;
                if (wdata_q[8 + `NVRC_ST_BULK_REJ]) bulk_rej_q <= 1'b0;
                if (wdata_q[8 + `NVRC_ST_WPROT]) wprot_q <= 1'b0;
                if (wdata_q[8 + `NVRC_ST_STORE_REJ]) store_rej_q <= 1'b0;
            end
            if (wr_go && awaddr_q == `NVRC_OFF_ADDR_LO && wstrb_q[0]) begin
                address_low_byte_q <= wdata_q[7:0];
            end
            if (wr_go && awaddr_q == `NVRC_OFF_ADDR_HI && wstrb_q[0]) begin
                address_high_byte_q <= wdata_q[6:0];
            end
            // read trigger; refused when the device is guarded
            if (trig_rd && !rd_q && !reg_locked) begin
                rd_q <= 1'b1;
            end
            if (reg_rd_done) begin
                rd_q <= 1'b0;
            end
            // write trigger: row program, row erase or eeprom word
            if (wr_ctrl && wdata_q[5] && wren_q && !reg_locked) begin
                if (space_select_bit_q && nv_addr >= `NVRC_EE_BASE) begin
                    ee_write_q <= 1'b1;
                    prog_data_q <= {6'h00, data_low_byte_q};
                end else if (!space_select_bit_q && wp_hit) begin
                    wprot_q <= 1'b1;
                end else if (free_q) begin
                    erase_row_q <= 1'b1;
                end else begin
                    prog_row_q <= 1'b1;
                    prog_data_q <= latch_rd;
                end
            end
            if ((trig_rd || (wr_ctrl && wdata_q[5])) && reg_locked) begin
                blocked_q <= 1'b1;
            end
            if (trig_bulk) begin
                bulk_rej_q <= 1'b1;
            end
            if (ptr_wr) begin
                store_rej_q <= 1'b1;
            end
        end
    end

    // ****************************************
    // read engine: one word, one stall cycle
    // ****************************************
    wire ptr_pfm = indirect_pointer[15];
    wire ptr_ee = ~indirect_pointer[15] && (indirect_pointer[14:8] == 7'h70);
    reg ptr_pend_q;
    reg ptr_is_ee_q;
    reg reg_kind_q;
    assign reg_rd_done = pend_q;
    always @(posedge aclk) begin
        if (!aresetn) begin
            pend_q <= 1'b0;
            ptr_pend_q <= 1'b0;
            ptr_is_ee_q <= 1'b0;
            reg_kind_q <= 1'b0;
            cpu_stall_q <= 1'b0;
            ptr_valid_q <= 1'b0;
            ptr_data_q <= 14'h0000;
            data_low_byte_q <= 8'h00;
            data_high_byte_q <= 6'h00;
            pfm_addr_q <= {PFM_AW{1'b0}};
            ee_addr_q <= 8'h00;
            cfg_addr_q <= 15'h0000;
        end else begin
            pend_q <= 1'b0;
            ptr_pend_q <= 1'b0;
            ptr_valid_q <= 1'b0;
            cpu_stall_q <= 1'b0;
            if (ptr_rd && (ptr_pfm || ptr_ee)) begin // pointer reads ignore code guard
                pfm_addr_q <= indirect_pointer[PFM_AW-1:0];
                ee_addr_q <= indirect_pointer[7:0];
                ptr_is_ee_q <= ptr_ee;
                ptr_pend_q <= 1'b1;
                cpu_stall_q <= 1'b1;
            end else if (rd_q && !pend_q && !ptr_pend_q) begin
                pfm_addr_q <= nv_addr[PFM_AW-1:0];
                ee_addr_q <= nv_addr[7:0];
                cfg_addr_q <= nv_addr;
                reg_kind_q <= space_select_bit_q;
                pend_q <= 1'b1;
                cpu_stall_q <= 1'b1;
            end
            if (ptr_pend_q) begin
                ptr_data_q <= ptr_is_ee_q ? {6'h00, ee_rdata} : pfm_rdata;
                ptr_valid_q <= 1'b1;
            end
            if (pend_q) begin
                // space bit picks flash or id/config/eeprom space
                if (!reg_kind_q) begin
                    {data_high_byte_q, data_low_byte_q} <= pfm_rdata;
                end else if (cfg_addr_q >= `NVRC_EE_BASE) begin
                    {data_high_byte_q, data_low_byte_q} <= {6'h00, ee_rdata};
                end else begin
                    {data_high_byte_q, data_low_byte_q} <= cfg_rdata;
                end
            end else begin
                if (wr_dlo) data_low_byte_q <= wdata_q[7:0];
                if (wr_dhi) data_high_byte_q <= wdata_q[5:0];
            end
        end
    end

    // ****************************************
    // write latches
    // ****************************************
    nvrc_latch_bank #(
        .WORDS(ROW_WORDS),
        .AW(5)
    ) u_latch (
        .aclk(aclk),
        .aresetn(aresetn),
        .load(latch_load),
        .load_data({wdata_q[5:0], data_low_byte_q}),
        .clear(prog_row_q),
        .rd_idx(nv_addr[4:0]),
        .rd_data(latch_rd),
        .fill_idx(fill_idx)
    );

    // ****************************************
    // axi read channel
    // ****************************************
    reg [31:0] rd_mux;
    always @* begin
        case ({s_axi_araddr[11:2], 2'b00})
            `NVRC_OFF_CTRL: rd_mux = {27'h000_0000, 1'b0, free_q, wren_q, space_select_bit_q, rd_q};
            `NVRC_OFF_ADDR_LO: rd_mux = {24'h00_0000, address_low_byte_q};
            `NVRC_OFF_ADDR_HI: rd_mux = {25'h000_0000, address_high_byte_q};
            `NVRC_OFF_DATA_LO: rd_mux = {24'h00_0000, data_low_byte_q};
            `NVRC_OFF_DATA_HI: rd_mux = {26'h000_0000, data_high_byte_q};
            `NVRC_OFF_STATUS: rd_mux = {27'h000_0000, store_rej_q, wprot_q, bulk_rej_q, blocked_q, rd_q | pend_q};
            `NVRC_OFF_LATCH: rd_mux = {27'h000_0000, fill_idx};
            default: rd_mux = 32'h0000_0000;
        endcase
    end
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `NVRC_RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= (s_axi_araddr[11:2] > 10'd6) ? `NVRC_RESP_SLVERR : `NVRC_RESP_OKAY;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// ---- nvrc_ctrl_properties.sv ----
// Purpose: port-level checks of the read access controller
// Assumes: single clock domain, synchronous active-low reset
// Notes: bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
module nvrc_ctrl_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ptr_rd,
    input wire logic ptr_wr,
    input wire logic cpu_stall_q,
    input wire logic ptr_valid_q,
    input wire logic prog_row_q,
    input wire logic erase_row_q,
    input wire logic ee_write_q,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ****************************************
    // pointer read steps
    // ****************************************
    sequence ptr_read_s;
        ##1 cpu_stall_q ##1 (ptr_valid_q && !cpu_stall_q);
    endsequence
    sequence no_write_s;
        (!(prog_row_q || erase_row_q || ee_write_q))[*3];
    endsequence
    ptr_read_seq_a: assert property (ptr_rd |-> ptr_read_s) else $error("pointer read timing off");
    stall_single_a: assert property (cpu_stall_q |=> !cpu_stall_q) else $error("stall longer than one cycle");
    valid_after_stall_a: assert property (ptr_valid_q |-> $past(cpu_stall_q)) else $error("data without stall");
    valid_single_a: assert property (ptr_valid_q |=> !ptr_valid_q) else $error("more than one word");
    store_no_write_a: assert property (ptr_wr |-> no_write_s) else $error("pointer store wrote memory");
    // ****************************************
    // register bus answers
    // ****************************************
    read_answer_a: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_arready && s_axi_rvalid)
        else $error("read not answered");
    rvalid_single_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read answered twice");
    bvalid_single_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write answered twice");
endmodule
`default_nettype wire

// ---- nvrc_ctrl_tb.sv ----
// Purpose: self-checking bench for the read access controller
// Assumes: data low register holds word bits 7:0, data high bits 13:8
// Notes: array model stands behind the read ports
`timescale 1ns/1ps
`default_nettype none
`include "nvrc_defs.vh"
module nvrc_ctrl_tb;
    reg aclk = 0, aresetn = 0;
    reg [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    reg [31:0] s_axi_wdata = 0;
    reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    reg ptr_rd = 0, ptr_wr = 0;
    reg [15:0] indirect_pointer = 0;
    wire [13:0] ptr_data_q, pfm_rdata, cfg_rdata, prog_data_q;
    wire ptr_valid_q, cpu_stall_q, prog_row_q, erase_row_q, ee_write_q;
    reg [1:0] guard_n = 2'b11;
    reg [1:0] wguard = 2'b11;
    wire [12:0] pfm_addr_q;
    wire [7:0] ee_addr_q, ee_rdata;
    wire [14:0] cfg_addr_q;
    integer n_errors = 0, n_checks = 0;
    reg [31:0] rd_v;
    reg [1:0] rsp;
    always #2.5 aclk = ~aclk;
    nvrc_ctrl dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ptr_rd(ptr_rd), .ptr_wr(ptr_wr),
        .indirect_pointer(indirect_pointer), .ptr_data_q(ptr_data_q), .ptr_valid_q(ptr_valid_q),
        .cpu_stall_q(cpu_stall_q), .code_guard_flash_n(guard_n[0]), .code_guard_eeprom_n(guard_n[1]),
        .write_guard_range(wguard), .pfm_addr_q(pfm_addr_q), .pfm_rdata(pfm_rdata), .ee_addr_q(ee_addr_q),
        .ee_rdata(ee_rdata), .cfg_addr_q(cfg_addr_q), .cfg_rdata(cfg_rdata), .prog_row_q(prog_row_q),
        .erase_row_q(erase_row_q), .ee_write_q(ee_write_q), .prog_data_q(prog_data_q));
    nvrc_mem_model mem (.pfm_addr_q(pfm_addr_q), .ee_addr_q(ee_addr_q), .cfg_addr_q(cfg_addr_q),
        .pfm_rdata(pfm_rdata), .ee_rdata(ee_rdata), .cfg_rdata(cfg_rdata));
    // ****************************************
    // helpers
    // ****************************************
    function [13:0] pexp(input [12:0] a);
        pexp = (a[12:5] == 8'hff) ? 14'h3fff : ({1'b0, a} ^ 14'h1555);
    endfunction
    task finish_test;
        begin
            if (n_errors == 0 && n_checks > 0) $display("STATUS OK");
            else $display("STATUS NOT OK");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task tmo;
        begin
            n_errors = n_errors + 1;
            $display("wrong value at %0t: wait ran out", $time);
            finish_test;
        end
    endtask
    task axw(input [11:0] a, input [31:0] d);
        integer i;
        reg ad, wd;
        begin
            ad = 0;
            wd = 0;
            @(posedge aclk);
            s_axi_awaddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= 1;
            s_axi_wvalid <= 1;
            s_axi_bready <= 1;
            for (i = 0; i < 40 && !(ad && wd); i = i + 1) begin
                @(posedge aclk);
                if (s_axi_awready) begin
                    ad = 1;
                    s_axi_awvalid <= 0;
                end
                if (s_axi_wready) begin
                    wd = 1;
                    s_axi_wvalid <= 0;
                end
            end
            for (i = 0; i < 40 && s_axi_bvalid !== 1'b1; i = i + 1) @(posedge aclk);
            if (s_axi_bvalid !== 1'b1) tmo;
            rsp = s_axi_bresp;
            s_axi_bready <= 0;
        end
    endtask
    task axr(input [11:0] a);
        integer i;
        begin
            @(posedge aclk);
            s_axi_araddr <= a;
            s_axi_arvalid <= 1;
            s_axi_rready <= 1;
            for (i = 0; i < 40 && s_axi_rvalid !== 1'b1; i = i + 1) begin
                @(posedge aclk);
                if (s_axi_arready) s_axi_arvalid <= 0;
            end
            if (s_axi_rvalid !== 1'b1) tmo;
            rd_v = s_axi_rdata;
            rsp = s_axi_rresp;
            s_axi_rready <= 0;
        end
    endtask
    task ptr_read(input [15:0] p, input [13:0] exp);
        begin
            @(posedge aclk);
            ptr_rd <= 1;
            indirect_pointer <= p;
            @(posedge aclk);
            ptr_rd <= 0;
            #1 chk(cpu_stall_q, 1);
            @(posedge aclk);
            #1 chk(ptr_valid_q, 1);
            chk(ptr_data_q, exp);
        end
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task t_ptr;
        begin
            ptr_read(16'h8000, pexp(13'h0000));
            ptr_read(16'h8123, pexp(13'h0123));
            ptr_read(16'h9fff, 14'h3fff);
            ptr_read(16'h7000, 14'h005a);
            ptr_read(16'h70ff, 14'h00a5);
        end
    endtask
    task t_store;
        integer i;
        begin
            @(posedge aclk);
            ptr_wr <= 1;
            indirect_pointer <= 16'h8010;
            @(posedge aclk);
            ptr_wr <= 0;
            for (i = 0; i < 3; i = i + 1) begin
                @(posedge aclk);
                #1 chk(prog_row_q | erase_row_q | ee_write_q, 0);
            end
            axr(`NVRC_OFF_STATUS);
            chk(rd_v[`NVRC_ST_STORE_REJ], 1);
        end
    endtask
    task t_reg(input sp, input [15:0] a, input [13:0] exp);
        integer j;
        begin
            axw(`NVRC_OFF_ADDR_LO, {24'h0, a[7:0]});
            axw(`NVRC_OFF_ADDR_HI, {24'h0, a[15:8]});
            axw(`NVRC_OFF_CTRL, {30'h0, sp, 1'b1});
            for (j = 0; j < 10; j = j + 1) begin
                axr(`NVRC_OFF_CTRL);
                if (rd_v[0] === 1'b0) break;
            end
            chk(rd_v[0], 0);
            axr(`NVRC_OFF_DATA_LO);
            chk(rd_v, {24'h0, exp[7:0]});
            axr(`NVRC_OFF_DATA_HI);
            chk(rd_v, {26'h0, exp[13:8]});
            axr(`NVRC_OFF_DATA_LO);
            chk(rd_v, {24'h0, exp[7:0]});
        end
    endtask
    task t_misc;
        begin
            axr(12'h01c);
            chk(rsp, `NVRC_RESP_SLVERR);
            chk(rd_v, 0);
            axw(12'h01c, 32'h0000_0001);
            chk(rsp, `NVRC_RESP_SLVERR);
            axw(`NVRC_OFF_CTRL, 32'h0000_0034);
            axr(`NVRC_OFF_STATUS);
            chk(rd_v[`NVRC_ST_BULK_REJ], 1);
        end
    endtask
    task t_wprot;
        begin
            @(posedge aclk);
            wguard <= 2'b00;
            repeat (4) @(posedge aclk);
            axw(`NVRC_OFF_CTRL, 32'h0000_0004);
            axw(`NVRC_OFF_CTRL, 32'h0000_0024);
            axr(`NVRC_OFF_STATUS);
            chk(rd_v[`NVRC_ST_WPROT], 1);
            @(posedge aclk);
            wguard <= 2'b11;
        end
    endtask
    task t_guard(input [1:0] g);
        begin
            @(posedge aclk);
            guard_n <= g;
            repeat (4) @(posedge aclk);
            axw(`NVRC_OFF_CTRL, 32'h0000_0200);
            axr(`NVRC_OFF_STATUS);
            chk(rd_v[`NVRC_ST_BLOCKED], 0);
            axw(`NVRC_OFF_ADDR_LO, 32'h0000_0050);
            axw(`NVRC_OFF_CTRL, 32'h0000_0001);
            axr(`NVRC_OFF_STATUS);
            chk(rd_v[`NVRC_ST_BLOCKED], 1);
            axr(`NVRC_OFF_DATA_LO);
            chk(rd_v, 32'h0000_005f);
            @(posedge aclk);
            guard_n <= 2'b11;
            repeat (4) @(posedge aclk);
        end
    endtask
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        repeat (3) @(posedge aclk);
        t_ptr;
        t_store;
        t_reg(1'b0, 16'h0123, pexp(13'h0123));
        t_reg(1'b1, 16'h7005, 14'h005f);
        t_misc;
        t_wprot;
        t_guard(2'b10);
        t_guard(2'b01);
        finish_test;
    end
endmodule
bind nvrc_ctrl nvrc_ctrl_checker u_chk (.aclk(aclk), .aresetn(aresetn), .ptr_rd(ptr_rd), .ptr_wr(ptr_wr),
    .cpu_stall_q(cpu_stall_q), .ptr_valid_q(ptr_valid_q), .prog_row_q(prog_row_q), .erase_row_q(erase_row_q),
    .ee_write_q(ee_write_q), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready));
`default_nettype wire

// ---- nvrc_defs.vh ----
// Purpose: constants for the nonvolatile read access controller
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes: offsets are byte addresses
`ifndef NVRC_DEFS_VH
`define NVRC_DEFS_VH

// register byte offsets
`define NVRC_OFF_CTRL      12'h000
`define NVRC_OFF_ADDR_LO   12'h004
`define NVRC_OFF_ADDR_HI   12'h008
`define NVRC_OFF_DATA_LO   12'h00c
`define NVRC_OFF_DATA_HI   12'h010
`define NVRC_OFF_STATUS    12'h014
`define NVRC_OFF_LATCH     12'h018

// control register fields
`define NVRC_CTRL_RD       0
`define NVRC_CTRL_SPACE    1
`define NVRC_CTRL_WREN     2
`define NVRC_CTRL_FREE     3
`define NVRC_CTRL_BULK     4

// status register fields
`define NVRC_ST_BUSY       0
`define NVRC_ST_BLOCKED    1
`define NVRC_ST_BULK_REJ   2
`define NVRC_ST_WPROT      3
`define NVRC_ST_STORE_REJ  4

// memory geometry
`define NVRC_PFM_WORDS     8192
`define NVRC_ROW_WORDS     32
`define NVRC_EE_BYTES      256
`define NVRC_EE_BASE       15'h7000
`define NVRC_ERASED_WORD   14'h3fff

// axi responses
`define NVRC_RESP_OKAY     2'b00
`define NVRC_RESP_SLVERR   2'b10

`endif

// ---- nvrc_latch_bank.v ----
// Purpose: row write latches, filled only through the data register pair
// Assumes: index advances per load, wraps at the row size
// Notes: no direct write addressing from outside; reads are addressed by rd_idx
`timescale 1ns/1ps
`default_nettype none
`include "nvrc_defs.vh"
module nvrc_latch_bank #(
    parameter WORDS = 32,
    parameter AW = 5
) (
    input wire aclk,
    input wire aresetn,
    input wire load,
    input wire [13:0] load_data,
    input wire clear,
    input wire [AW-1:0] rd_idx,
    output wire [13:0] rd_data,
    output wire [AW-1:0] fill_idx
);
    reg [13:0] mem [0:WORDS-1];
    reg [AW-1:0] idx_q;
    integer i;

    always @(posedge aclk) begin
        if (!aresetn || clear) begin
            idx_q <= {AW{1'b0}};
            for (i = 0; i < WORDS; i = i + 1) begin
                mem[i] <= `NVRC_ERASED_WORD;
            end
        end else if (load) begin
            mem[idx_q] <= load_data;
            idx_q <= idx_q + 1'b1;
        end
    end

    assign rd_data = mem[rd_idx];
    assign fill_idx = idx_q;
endmodule
`default_nettype wire

// ---- nvrc_mem_model.sv ----
// Purpose: behavioural model of the flash, eeprom and config arrays
// Assumes: reads answer combinationally from the registered addresses
// Notes: top row of flash stays erased, the rest holds an address pattern
`timescale 1ns/1ps
`default_nettype none
module nvrc_mem_model (
    input wire logic [12:0] pfm_addr_q,
    input wire logic [7:0] ee_addr_q,
    input wire logic [14:0] cfg_addr_q,
    output logic [13:0] pfm_rdata,
    output logic [7:0] ee_rdata,
    output logic [13:0] cfg_rdata
);
    // 8192 words of 14 bits, last row erased to all ones
    assign pfm_rdata = (pfm_addr_q[12:5] == 8'hff) ? 14'h3fff : ({1'b0, pfm_addr_q} ^ 14'h1555);
    assign ee_rdata = ee_addr_q ^ 8'h5a;
    assign cfg_rdata = cfg_addr_q[13:0] ^ 14'h0aaa;
endmodule
`default_nettype wire
